//--- hw/switch_fault_and_adc_status.sv
// Fault flags, conversion results and freshness flags read over the serial port
`include "fault_status_params.svh"
`default_nettype none
module switch_fault_and_adc_status (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// Register read port from the serial frame decoder
	input  wire logic                        read_strobe,
	input  wire logic [6:0]                  read_addr,
	output logic [23:0]                      read_data,
	output logic                             read_valid,
	// Protection and mode events
	input  wire logic                        fuse_trip_event,
	input  wire logic                        overcurrent_avg_above,
	input  wire logic [7:0]                  nominal_trip_time,
	input  wire logic                        die_overtemp_level,
	input  wire logic                        thermistor_below_threshold,
	input  wire logic                        output_on_state,
	input  wire logic                        gate_below_uv,
	input  wire logic                        pump_below_low,
	input  wire logic                        watchdog_failure,
	input  wire logic                        selftest_request,
	input  wire logic                        unlock_sequence,
	input  wire logic                        wakeup_entry,
	// Conversion results
	input  wire logic                        current_new,
	input  wire logic [12:0]                 current_value,
	input  wire logic                        die_temp_new,
	input  wire logic [9:0]                  die_temp_value,
	input  wire logic                        thermistor_new,
	input  wire logic [9:0]                  thermistor_value,
	input  wire logic                        drain_source_new,
	input  wire logic [9:0]                  drain_source_value,
	input  wire logic                        drain_source_selftest,
	input  wire logic                        output_voltage_new,
	input  wire logic [9:0]                  output_voltage_value,
	// Shutdown commands
	output logic                             fet_enable_allowed,
	output logic                             bypass_enable_allowed,
	output logic                             pump_enable_allowed,
	output logic                             locked_mode
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic fault_status_pkg::word_type with_parity(input fault_status_pkg::word_type w);
		fault_status_pkg::word_type r;
		r    = w;
		r[0] = ~(^w[23:1]);
		return r;
	endfunction : with_parity

	function automatic logic set_or_clear(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction : set_or_clear

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	logic rd_fault;
	logic rd_curr;
	logic rd_temp;
	logic rd_volt;
	assign rd_fault = read_strobe && (read_addr == `ADDR_FAULT_STATUS_LOW);
	assign rd_curr  = read_strobe && (read_addr == `ADDR_CURRENT_SENSE);
	assign rd_temp  = read_strobe && (read_addr == `ADDR_TEMPERATURE);
	assign rd_volt  = read_strobe && (read_addr == `ADDR_VOLTAGE);

	// ----------------------------------------------------------------
	// Fault flags (die overtemp and pump low follow their levels, the others latch)
	// ----------------------------------------------------------------
	logic fuse_trip_flag;
	logic ext_fet_overtemp_flag;
	logic gate_undervolt_flag;
	logic watchdog_fault_flag;
	logic bypass_desat_flag;
	logic gate_qualified;
	logic pump_low_flag;
	logic die_overtemp_flag;
	logic overcurrent_warning;

	deglitch_timer #(.CYCLES(`GATE_DEGLITCH_CYCLES)) gate_filter (
		.clk      (clk),
		.rstn     (rstn),
		.level    (gate_below_uv && output_on_state),
		.qualified(gate_qualified)
	);

	deglitch_timer #(.CYCLES(`PUMP_RISE_CYCLES)) pump_filter (
		.clk      (clk),
		.rstn     (rstn),
		.level    (pump_below_low),
		.qualified(pump_low_flag)
	);

	// Set wins over a read in the same cycle, so no event is lost
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fuse_trip_flag        <= 1'b0;
			ext_fet_overtemp_flag <= 1'b0;
			gate_undervolt_flag   <= 1'b0;
			watchdog_fault_flag   <= 1'b0;
			bypass_desat_flag     <= 1'b0;
		end else begin
			fuse_trip_flag        <= set_or_clear(fuse_trip_flag, fuse_trip_event, rd_fault);
			ext_fet_overtemp_flag <= set_or_clear(ext_fet_overtemp_flag, thermistor_below_threshold, rd_fault);
			gate_undervolt_flag   <= set_or_clear(gate_undervolt_flag, gate_qualified, rd_fault);
			watchdog_fault_flag   <= set_or_clear(watchdog_fault_flag,
				watchdog_failure && (lock_state != fault_status_pkg::lock_locked), rd_fault);
			bypass_desat_flag     <= set_or_clear(bypass_desat_flag, wakeup_entry, rd_fault);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			die_overtemp_flag <= 1'b0;
		end else begin
			die_overtemp_flag <= die_overtemp_level;
		end
	end

	// ----------------------------------------------------------------
	// Overcurrent warning with memory
	// ----------------------------------------------------------------
	// The hold is a simple count standing in for the current-dependent
	// decay; after a trip it scales with the programmed trip time.
	logic [15:0] ovc_hold;
	logic        trip_seen;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overcurrent_warning <= 1'b0;
			ovc_hold            <= 16'h0000;
			trip_seen           <= 1'b0;
		end else if (fuse_trip_event || (trip_seen && overcurrent_avg_above)) begin
			// A trip always comes with high current, so it must win or the longer hold is never used
			overcurrent_warning <= overcurrent_warning || overcurrent_avg_above;
			ovc_hold            <= 16'({nominal_trip_time, 3'h0}) + 16'(`OVC_HOLD_SCALE);
			trip_seen           <= 1'b1;
		end else if (overcurrent_avg_above) begin
			overcurrent_warning <= 1'b1;
			ovc_hold            <= 16'(`OVC_HOLD_SCALE);
		end else if (overcurrent_warning || trip_seen) begin
			if (ovc_hold == 16'h0000) begin
				overcurrent_warning <= 1'b0;
				trip_seen           <= 1'b0;
			end else begin
				ovc_hold <= ovc_hold - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Lock state
	// ----------------------------------------------------------------
	fault_status_pkg::lock_state_type lock_state;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_state <= fault_status_pkg::lock_locked;
		end else begin
			unique case (lock_state)
				fault_status_pkg::lock_unlocked: begin
					if (watchdog_failure)
						lock_state <= fault_status_pkg::lock_locked;
					else if (selftest_request)
						lock_state <= fault_status_pkg::lock_selftest;
				end
				fault_status_pkg::lock_selftest: begin
					if (watchdog_failure)
						lock_state <= fault_status_pkg::lock_locked;
					else if (!selftest_request)
						lock_state <= fault_status_pkg::lock_unlocked;
				end
				fault_status_pkg::lock_locked: begin
					if (unlock_sequence && !watchdog_fault_flag)
						lock_state <= fault_status_pkg::lock_unlocked;
				end
				default: lock_state <= fault_status_pkg::lock_locked;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shutdown outputs
	// ----------------------------------------------------------------
	// Built from the registered flags, so outputs lag the flags by one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fet_enable_allowed    <= 1'b0;
			bypass_enable_allowed <= 1'b0;
			pump_enable_allowed   <= 1'b0;
			locked_mode           <= 1'b1;
		end else begin
			fet_enable_allowed    <= !fuse_trip_flag && !die_overtemp_flag && !ext_fet_overtemp_flag
				&& !gate_undervolt_flag && !pump_low_flag;
			bypass_enable_allowed <= !fuse_trip_flag && !die_overtemp_flag && !ext_fet_overtemp_flag
				&& !bypass_desat_flag;
			pump_enable_allowed   <= !die_overtemp_flag;
			locked_mode           <= (lock_state == fault_status_pkg::lock_locked);
		end
	end

	// ----------------------------------------------------------------
	// Conversion results and freshness flags
	// ----------------------------------------------------------------
	fault_status_pkg::code13_type current_code;
	fault_status_pkg::code10_type die_temp_code;
	fault_status_pkg::code10_type thermistor_code;
	fault_status_pkg::code10_type drain_source_code;
	fault_status_pkg::code10_type output_voltage_code;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			current_code        <= 13'h0000;
			die_temp_code       <= 10'h000;
			thermistor_code     <= 10'h000;
			drain_source_code   <= 10'h000;
			output_voltage_code <= 10'h000;
		end else begin
			if (current_new)
				current_code <= current_value;
			if (die_temp_new)
				die_temp_code <= die_temp_value;
			if (thermistor_new)
				thermistor_code <= thermistor_value;
			if (drain_source_new && !drain_source_selftest)
				drain_source_code <= drain_source_value;
			if (output_voltage_new)
				output_voltage_code <= output_voltage_value;
		end
	end

	logic current_fresh_flag;
	logic die_temp_fresh_flag;
	logic thermistor_fresh_flag;
	logic drain_source_fresh_flag;
	logic output_voltage_fresh_flag;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			current_fresh_flag        <= 1'b0;
			die_temp_fresh_flag       <= 1'b0;
			thermistor_fresh_flag     <= 1'b0;
			drain_source_fresh_flag   <= 1'b0;
			output_voltage_fresh_flag <= 1'b0;
		end else begin
			current_fresh_flag        <= set_or_clear(current_fresh_flag, current_new, rd_curr);
			die_temp_fresh_flag       <= set_or_clear(die_temp_fresh_flag, die_temp_new, rd_temp);
			thermistor_fresh_flag     <= set_or_clear(thermistor_fresh_flag, thermistor_new, rd_temp);
			drain_source_fresh_flag   <= set_or_clear(drain_source_fresh_flag,
				drain_source_new && !drain_source_selftest, rd_volt);
			output_voltage_fresh_flag <= set_or_clear(output_voltage_fresh_flag, output_voltage_new, rd_volt);
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	fault_status_pkg::word_type next_read_data;

	always_comb begin
		next_read_data = 24'h000000;
		if (rd_fault) begin
			next_read_data[`BIT_BYPASS_DESAT]   = bypass_desat_flag;
			next_read_data[`BIT_FUSE_TRIP]      = fuse_trip_flag;
			next_read_data[`BIT_OVERCURRENT]    = overcurrent_warning;
			next_read_data[`BIT_DIE_OVERTEMP]   = die_overtemp_flag;
			next_read_data[`BIT_EXT_OVERTEMP]   = ext_fet_overtemp_flag;
			next_read_data[`BIT_GATE_UNDERVOLT] = gate_undervolt_flag;
			next_read_data[`BIT_PUMP_LOW]       = pump_low_flag;
			next_read_data[`BIT_WATCHDOG_FAULT] = watchdog_fault_flag;
		end else if (rd_curr) begin
			next_read_data[`CURR_LSB +: 13]     = current_code;
			next_read_data[`BIT_LOW_FRESH]      = current_fresh_flag;
		end else if (rd_temp) begin
			next_read_data[`HIGH_CODE_LSB +: 10] = die_temp_code;
			next_read_data[`BIT_HIGH_FRESH]      = die_temp_fresh_flag;
			next_read_data[`LOW_CODE_LSB +: 10]  = thermistor_code;
			next_read_data[`BIT_LOW_FRESH]       = thermistor_fresh_flag;
		end else if (rd_volt) begin
			next_read_data[`HIGH_CODE_LSB +: 10] = drain_source_code;
			next_read_data[`BIT_HIGH_FRESH]      = drain_source_fresh_flag;
			next_read_data[`LOW_CODE_LSB +: 10]  = output_voltage_code;
			next_read_data[`BIT_LOW_FRESH]       = output_voltage_fresh_flag;
		end
		next_read_data = with_parity(next_read_data);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			read_data  <= 24'h000001;
			read_valid <= 1'b0;
		end else begin
			read_valid <= read_strobe;
			if (read_strobe)
				read_data <= next_read_data;
		end
	end
endmodule : switch_fault_and_adc_status
`default_nettype wire

//--- shared/fault_status_params.svh
// Constants for the switch fault and conversion status register bank
`ifndef FAULT_STATUS_PARAMS_SVH
`define FAULT_STATUS_PARAMS_SVH

`define ADDR_FAULT_STATUS_LOW   7'h11
`define ADDR_CURRENT_SENSE      7'h12
`define ADDR_TEMPERATURE        7'h13
`define ADDR_VOLTAGE            7'h14

`define BIT_FUSE_TRIP           7
`define BIT_OVERCURRENT         6
`define BIT_DIE_OVERTEMP        5
`define BIT_EXT_OVERTEMP        4
`define BIT_GATE_UNDERVOLT      3
`define BIT_PUMP_LOW            2
`define BIT_WATCHDOG_FAULT      1
`define BIT_BYPASS_DESAT        8
`define BIT_LOW_FRESH           1
`define BIT_HIGH_FRESH          12

`define CURR_LSB                2
`define HIGH_CODE_LSB           13
`define LOW_CODE_LSB            2

`define CLK_PERIOD_NS           5
`define GATE_DEGLITCH_NS        40
`define PUMP_RISE_NS            40
`define GATE_DEGLITCH_CYCLES    ((`GATE_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PUMP_RISE_CYCLES        ((`PUMP_RISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVC_HOLD_SCALE          8

`endif

//--- shared/fault_status_pkg.sv
// Types shared by the fault and conversion status register bank
`default_nettype none
package fault_status_pkg;
	typedef logic [23:0] word_type;
	typedef logic [9:0]  code10_type;
	typedef logic [12:0] code13_type;
	typedef enum logic [2:0] {
		lock_unlocked = 3'h1,
		lock_selftest = 3'h2,
		lock_locked   = 3'h4
	} lock_state_type;
endpackage : fault_status_pkg
`default_nettype wire

//--- hw/deglitch_timer.sv
// Qualifies a level that must persist for a number of cycles
`default_nettype none
module deglitch_timer #(
	parameter int CYCLES = 8
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic level,
	output logic      qualified
);
	logic [15:0] count;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count     <= 16'h0000;
			qualified <= 1'b0;
		end else if (!level) begin
			count     <= 16'h0000;
			qualified <= 1'b0;
		end else if (count >= 16'(CYCLES - 1)) begin
			qualified <= 1'b1;
		end else begin
			count <= count + 16'h0001;
		end
	end
endmodule : deglitch_timer
`default_nettype wire

//--- tb/fault_status_props.sv
// Concurrent checks on the ports of the status register bank
`include "fault_status_params.svh"
`default_nettype none
module fault_status_props (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        read_strobe,
	input wire logic [6:0]  read_addr,
	input wire logic [23:0] read_data,
	input wire logic        read_valid,
	input wire logic        current_new,
	input wire logic        fuse_trip_event,
	input wire logic        die_overtemp_level,
	input wire logic        pump_below_low,
	input wire logic        watchdog_failure,
	input wire logic        fet_enable_allowed,
	input wire logic        bypass_enable_allowed,
	input wire logic        pump_enable_allowed,
	input wire logic        locked_mode
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_rd_fault; read_strobe && read_addr == `ADDR_FAULT_STATUS_LOW; endsequence
	sequence s_rd_curr; read_strobe && read_addr == `ADDR_CURRENT_SENSE && !current_new; endsequence
	chk_read_answer: assert property (read_strobe |=> read_valid) else $error("read not answered");
	chk_valid_cause: assert property (read_valid |-> $past(read_strobe)) else $error("stray read valid");
	chk_odd_parity: assert property (read_valid |-> ^read_data) else $error("even parity word");
	chk_unused_zero: assert property (s_rd_fault |=> read_data[23:9] == 15'h0000)
		else $error("unused fault bits set");
	chk_die_bit: assert property (die_overtemp_level [*2] ##0 s_rd_fault |=> read_data[`BIT_DIE_OVERTEMP])
		else $error("die overtemp bit missing");
	chk_die_off: assert property (die_overtemp_level [*3] |->
		!fet_enable_allowed && !pump_enable_allowed && !bypass_enable_allowed) else $error("die hot, drive on");
	chk_pump_off: assert property (pump_below_low [*8] ##1 pump_below_low [*5] |-> !fet_enable_allowed)
		else $error("pump low, fet on");
	chk_fuse_off: assert property (fuse_trip_event |-> ##[1:3] (!fet_enable_allowed && !bypass_enable_allowed))
		else $error("fuse trip, drive on");
	chk_wd_lock: assert property (watchdog_failure && !locked_mode |-> ##[1:3] locked_mode)
		else $error("watchdog did not lock");
	chk_fresh_clear: assert property (s_rd_curr ##1 s_rd_curr |=> !read_data[`BIT_LOW_FRESH])
		else $error("fresh flag not cleared");
endmodule : fault_status_props
bind switch_fault_and_adc_status fault_status_props i_props (.clk(clk), .rstn(rstn), .read_strobe(read_strobe),
	.read_addr(read_addr), .read_data(read_data), .read_valid(read_valid), .current_new(current_new),
	.fuse_trip_event(fuse_trip_event), .die_overtemp_level(die_overtemp_level), .pump_below_low(pump_below_low),
	.watchdog_failure(watchdog_failure), .fet_enable_allowed(fet_enable_allowed),
	.bypass_enable_allowed(bypass_enable_allowed), .pump_enable_allowed(pump_enable_allowed),
	.locked_mode(locked_mode));
`default_nettype wire

//--- tb/host_reader.sv
// Host side of the register read port: issues reads, checks word parity
`default_nettype none
module host_reader (
	input  wire logic        clk,
	input  wire logic [23:0] read_data,
	input  wire logic        read_valid,
	output logic             read_strobe,
	output logic [6:0]       read_addr,
	output int               parity_errors
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		read_strobe = 1'b0;
		read_addr = 7'h00;
		parity_errors = 0;
	end
	// Back to back reads of one address, n strobes long
	task automatic rd(input logic [6:0] a, input int n);
		@(posedge clk);
		#1;
		read_strobe = 1'b1;
		read_addr = a;
		repeat (n) @(posedge clk);
		#1;
		read_strobe = 1'b0;
		// Idle address lines must not look like a valid request
		read_addr = ~a;
	endtask : rd
	always @(posedge clk) begin
		if (read_valid === 1'b1 && ^read_data !== 1'b1) begin
			parity_errors++;
		end
	end
endmodule : host_reader
`default_nettype wire

//--- tb/switch_fault_and_adc_status_test.sv
// Self-checking bench for the fault and conversion status register bank
`include "fault_status_params.svh"
`default_nettype none
module switch_fault_and_adc_status_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rstn, read_strobe, read_valid, lck, fen, ben, pen;
	logic [6:0] read_addr;
	logic [23:0] read_data;
	logic [11:0] ev;
	logic [4:0] nw;
	logic [12:0] cur;
	logic [9:0] dt, th, ds, vo;
	logic [7:0] ntt;
	logic [31:0] r;
	logic [47:0] notes[$];
	logic [47:0] note;
	int err_count, check_count, perr;
	int ev_i [8] = '{1, 2, 6, 3, 5, 5, 0, 10};
	int hold [8] = '{3, 3, 16, 2, 4, 10, 1, 1};
	int fbit [8] = '{6, 5, 2, 4, 3, 3, 7, 8};
	logic [2:0] ex [8] = '{3'b011, 3'b001, 3'b001, 3'b011, 3'b000, 3'b011, 3'b011, 3'b011};
	host_reader i_host (.clk(clk), .read_data(read_data), .read_valid(read_valid), .read_strobe(read_strobe),
		.read_addr(read_addr), .parity_errors(perr));
	// Selftest inverts the drain-source input so a frozen field shows up
	switch_fault_and_adc_status i_dut (.clk(clk), .rstn(rstn), .read_strobe(read_strobe),
		.read_addr(read_addr), .read_data(read_data), .read_valid(read_valid), .fuse_trip_event(ev[0]),
		.overcurrent_avg_above(ev[1]), .nominal_trip_time(ntt), .die_overtemp_level(ev[2]),
		.thermistor_below_threshold(ev[3]), .output_on_state(ev[4]), .gate_below_uv(ev[5]),
		.pump_below_low(ev[6]), .watchdog_failure(ev[7]), .selftest_request(ev[8]), .unlock_sequence(ev[9]),
		.wakeup_entry(ev[10]), .current_new(nw[0]), .current_value(cur), .die_temp_new(nw[1]),
		.die_temp_value(dt), .thermistor_new(nw[2]), .thermistor_value(th), .drain_source_new(nw[3]),
		.drain_source_value(ds ^ {10{ev[11]}}), .drain_source_selftest(ev[11]), .output_voltage_new(nw[4]),
		.output_voltage_value(vo), .fet_enable_allowed(fen), .bypass_enable_allowed(ben), .pump_enable_allowed(pen),
		.locked_mode(lck));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic fault_status_pkg::word_type w(input logic [23:1] b);
		return {b, ~^b};
	endfunction : w
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic rd2(input logic [6:0] a, input logic [23:1] b1, input logic [23:1] b2);
		notes.push_back({24'hffffff, w(b1)});
		notes.push_back({24'hffffff, w(b2)});
		i_host.rd(a, 2);
	endtask : rd2
	task automatic rdb(input int k, input logic e);
		notes.push_back({24'h000001 << k, 24'(e) << k});
		i_host.rd(`ADDR_FAULT_STATUS_LOW, 1);
	endtask : rdb
	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: level %b expected %b", $time, got, exp);
		end
	endtask : chk
	task automatic pulse(input int k);
		ev[k] = 1'b1;
		step(1);
		ev[k] = 1'b0;
		step(3);
	endtask : pulse
	task automatic complete_run;
		$display("checks %0d mismatches %0d parity errors %0d", check_count, err_count, perr);
		if (err_count == 0 && perr == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		if (read_valid === 1'b1) begin
			note = notes.pop_front();
			check_count++;
			if ((read_data & note[47:24]) !== note[23:0]) begin
				err_count++;
				$display("wrong value at %0t: read %h expected %h", $time, read_data, note[23:0]);
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#20000;
		err_count++;
		complete_run();
	end
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		{ev, nw, cur, dt, th, ds, vo, ntt} = '0;
		err_count = 0;
		check_count = 0;
		r = 32'h183340ff;
		rstn = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rstn = 1'b1;
		for (int a = 8'h11; a < 8'h16; a++) rd2(7'(a), '0, '0);
		chk(fen, 1'b1);
		chk(ben, 1'b1);
		chk(pen, 1'b1);
		$display("test reset values done");
		for (int i = 0; i < 3; i++) begin
			r = lfsr(r);
			cur = r[12:0];
			vo = r[22:13];
			r = lfsr(lfsr(r));
			{dt, th, ds} = r[29:0];
			nw = 5'h1f;
			step(1);
			nw = 5'h00;
			rd2(`ADDR_CURRENT_SENSE, {9'h000, cur, 1'b1}, {9'h000, cur, 1'b0});
			rd2(`ADDR_TEMPERATURE, {1'b0, dt, 1'b1, th, 1'b1}, {1'b0, dt, 1'b0, th, 1'b0});
			rd2(`ADDR_VOLTAGE, {1'b0, ds, 1'b1, vo, 1'b1}, {1'b0, ds, 1'b0, vo, 1'b0});
		end
		ev[11] = 1'b1;
		nw = 5'h08;
		step(1);
		nw = 5'h00;
		rd2(`ADDR_VOLTAGE, {1'b0, ds, 1'b0, vo, 1'b0}, {1'b0, ds, 1'b0, vo, 1'b0});
		ev[11] = 1'b0;
		$display("test conversions done");
		ev[4] = 1'b1;
		for (int i = 0; i < 8; i++) begin
			ev[ev_i[i]] = 1'b1;
			step(hold[i]);
			rdb(fbit[i], ex[i][0]);
			ev[ev_i[i]] = 1'b0;
			step(3);
			rdb(fbit[i], ex[i][1]);
			step(12);
			rdb(fbit[i], ex[i][2]);
		end
		$display("test fault flags done");
		ntt = 8'h02;
		ev[1] = 1'b1;
		step(3);
		pulse(0);
		rdb(7, 1'b1);
		ev[1] = 1'b0;
		step(10);
		rdb(6, 1'b1);
		step(20);
		rdb(6, 1'b0);
		$display("test warning hold done");
		pulse(9);
		chk(lck, 1'b0);
		ev[8] = 1'b1;
		step(1);
		pulse(7);
		ev[8] = 1'b0;
		chk(lck, 1'b1);
		pulse(9);
		chk(lck, 1'b1);
		rdb(1, 1'b1);
		pulse(9);
		chk(lck, 1'b0);
		step(3);
		$display("test watchdog lock done");
		pulse(10);
		chk(ben, 1'b0);
		chk(fen, 1'b1);
		rdb(8, 1'b1);
		step(2);
		chk(ben, 1'b1);
		$display("test bypass rearm done");
		complete_run();
	end
endmodule : switch_fault_and_adc_status_test
`default_nettype wire
